// *** pkg/tsr_pkg.sv ***
// Purpose: Shared constants and types of the temperature sensor register file
// Assumes: One 40 MHz clock; byte events come from a serial engine on that clock
// Notes:   Read and write indices differ for several registers
package tsr_pkg;

  // Read indices
  localparam logic [7:0] TSR_RD_LOCAL_HI      = 8'h00;
  localparam logic [7:0] TSR_RD_REMOTE_HI     = 8'h01;
  localparam logic [7:0] TSR_RD_STATUS        = 8'h02;
  localparam logic [7:0] TSR_RD_SETUP         = 8'h03;
  localparam logic [7:0] TSR_RD_INTERVAL      = 8'h04;
  localparam logic [7:0] TSR_RD_LOCAL_UB      = 8'h05;
  localparam logic [7:0] TSR_RD_LOCAL_LB      = 8'h06;
  localparam logic [7:0] TSR_RD_REMOTE_UB_MSB = 8'h07;
  localparam logic [7:0] TSR_RD_REMOTE_LB_MSB = 8'h08;
  localparam logic [7:0] TSR_RD_REMOTE_LO     = 8'h10;
  localparam logic [7:0] TSR_RD_LOCAL_LO      = 8'h15;
  localparam logic [7:0] TSR_RD_MAKER         = 8'hFE;

  // Write indices
  localparam logic [7:0] TSR_WR_SETUP         = 8'h09;
  localparam logic [7:0] TSR_WR_INTERVAL      = 8'h0A;
  localparam logic [7:0] TSR_WR_LOCAL_UB      = 8'h0B;
  localparam logic [7:0] TSR_WR_LOCAL_LB      = 8'h0C;
  localparam logic [7:0] TSR_WR_REMOTE_UB_MSB = 8'h0D;
  localparam logic [7:0] TSR_WR_REMOTE_LB_MSB = 8'h0E;
  localparam logic [7:0] TSR_WR_ONE_SHOT      = 8'h0F;

  // Indices shared by read and write
  localparam logic [7:0] TSR_IX_OFFSET_MSB    = 8'h11;
  localparam logic [7:0] TSR_IX_OFFSET_LSB    = 8'h12;
  localparam logic [7:0] TSR_IX_REMOTE_UB_LSB = 8'h13;
  localparam logic [7:0] TSR_IX_REMOTE_LB_LSB = 8'h14;
  localparam logic [7:0] TSR_IX_REMOTE_CRIT   = 8'h19;
  localparam logic [7:0] TSR_IX_LOCAL_CRIT    = 8'h20;
  localparam logic [7:0] TSR_IX_HYST          = 8'h21;
  localparam logic [7:0] TSR_IX_FAULT_CNT     = 8'h22;
  localparam logic [7:0] TSR_IX_IDEALITY      = 8'h23;
  localparam logic [7:0] TSR_IX_SMOOTH        = 8'h24;

  // Field positions
  localparam int TSR_SETUP_MASK_BIT  = 7;
  localparam int TSR_SETUP_SD_BIT    = 6;
  localparam int TSR_SETUP_PIN6_BIT  = 5;
  localparam int TSR_SETUP_RANGE_BIT = 2;
  localparam int TSR_FAULT_TO_BIT    = 7;

  // Values after reset
  localparam logic [7:0]  TSR_PTR_RST       = 8'h00;
  localparam logic [7:0]  TSR_SETUP_RST     = 8'h00;
  localparam logic [3:0]  TSR_INTERVAL_RST  = 4'h8;
  localparam logic [7:0]  TSR_LOCAL_UB_RST  = 8'h55;
  localparam logic [7:0]  TSR_LOCAL_LB_RST  = 8'h00;
  localparam logic [11:0] TSR_REMOTE_UB_RST = 12'h550;
  localparam logic [11:0] TSR_REMOTE_LB_RST = 12'h000;
  localparam logic [11:0] TSR_OFFSET_RST    = 12'h000;
  localparam logic [7:0]  TSR_CRIT_RST      = 8'h6E;
  localparam logic [7:0]  TSR_HYST_RST      = 8'h0A;
  localparam logic [3:0]  TSR_FAULT_RST     = 4'h0;
  localparam logic [7:0]  TSR_IDEALITY_RST  = 8'h00;
  localparam logic [1:0]  TSR_SMOOTH_RST    = 2'h0;
  localparam logic [11:0] TSR_RESULT_RST    = 12'h000;

  // Phase of a write transaction
  typedef enum logic [2:0] {
    TSR_IDLE = 3'b001,
    TSR_PTR  = 3'b010,
    TSR_DATA = 3'b100
  } tsr_wphase_e;

  // Converter result with its update strobe
  typedef struct packed {
    logic        upd;
    logic [11:0] value;
  } tsr_result_s;

  // Settings handed to the converter, comparators and pin logic
  typedef struct packed {
    logic        mask_alert;
    logic        shutdown;
    logic        pin6_critical_mode;
    logic        wide_range;
    logic [3:0]  interval;
    logic [7:0]  local_upper_bound_bits;
    logic [7:0]  local_lower_bound_bits;
    logic [11:0] remote_upper_bound_bits;
    logic [11:0] remote_lower_bound_bits;
    logic [11:0] remote_offset_bits;
    logic [7:0]  remote_critical_bits;
    logic [7:0]  local_critical_bits;
    logic [7:0]  hysteresis_bits;
    logic        bus_timeout_en;
    logic [2:0]  fault_count;
    logic [7:0]  ideality_bits;
    logic [1:0]  smoothing;
  } tsr_ctrl_s;

endpackage

// *** verilog/tsr_result_pair.sv ***
// Purpose: One temperature result split in a high byte and a low nibble
// Assumes: rd_hi, rd_lo and rd_other are one-cycle read pulses
// Notes:   Reading one half freezes the other until it or another register is read
`timescale 1ns/1ps
`default_nettype none
module tsr_result_pair (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  // Converter side
  input  wire tsr_pkg::tsr_result_s result,
  // Read events
  input  wire logic                 rd_hi,
  input  wire logic                 rd_lo,
  input  wire logic                 rd_other,
  // Register contents
  output logic [7:0]                hi_byte,
  output logic [7:0]                lo_byte
);
  logic [7:0] hi_reg, hi_next;
  logic [3:0] lo_reg, lo_next;
  logic       lock_lo_reg, lock_lo_next;
  logic       lock_hi_reg, lock_hi_next;

  always_comb begin
    lock_lo_next = lock_lo_reg;
    lock_hi_next = lock_hi_reg;
    if (rd_other) begin
      lock_lo_next = 1'b0; // RL11
      lock_hi_next = 1'b0; // RL11
    end else if (rd_hi) begin
      lock_lo_next = ~lock_hi_reg; // RL9
      lock_hi_next = 1'b0;
    end else if (rd_lo) begin
      lock_hi_next = ~lock_lo_reg; // RL10
      lock_lo_next = 1'b0;
    end
    hi_next = hi_reg;
    lo_next = lo_reg;
    // The freeze acts in the reading cycle so a same-cycle update cannot split the pair
    if (result.upd && !lock_hi_next) begin
      hi_next = result.value[11:4]; // RL8
    end
    if (result.upd && !lock_lo_next) begin
      lo_next = result.value[3:0]; // RL8
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hi_reg      <= tsr_pkg::TSR_RESULT_RST[11:4]; // RL13
      lo_reg      <= tsr_pkg::TSR_RESULT_RST[3:0]; // RL13
      lock_lo_reg <= 1'b0;
      lock_hi_reg <= 1'b0;
    end else begin
      hi_reg      <= hi_next;
      lo_reg      <= lo_next;
      lock_lo_reg <= lock_lo_next;
      lock_hi_reg <= lock_hi_next;
    end
  end

  assign hi_byte = hi_reg;
  assign lo_byte = {lo_reg, 4'h0}; // RL7
endmodule
`default_nettype wire

// *** verilog/tsr_split12.sv ***
// Purpose: A 12-bit setting written as an upper byte and a low nibble
// Assumes: Write strobes are one-cycle pulses
// Notes:   Low nibble sits in bits 7 to 4 of its byte
`timescale 1ns/1ps
`default_nettype none
module tsr_split12 #(
  parameter logic [11:0] RST_VAL = 12'h000
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Write port
  input  wire logic        wr_msb,
  input  wire logic        wr_lsb,
  input  wire logic [7:0]  wdata,
  // Value
  output logic [11:0]      value
);
  logic [11:0] val_reg, val_next;

  always_comb begin
    val_next = val_reg;
    if (wr_msb) begin
      val_next[11:4] = wdata;
    end
    if (wr_lsb) begin
      val_next[3:0] = wdata[7:4];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      val_reg <= RST_VAL;
    end else begin
      val_reg <= val_next;
    end
  end

  assign value = val_reg;
endmodule
`default_nettype wire

// *** verilog/tsr_regfile.sv ***
// Purpose: Index-addressed register file of a local and remote temperature sensor
// Assumes: A serial engine on clk reports write starts, bytes, stops and read requests
// Notes:   Converter, comparators and status logic live outside and meet here by strobes
//
// What this block does
// [RL1] An 8-bit index selects the register
// [RL2] Every write reloads the index; reads reuse it
// [RL3] Index clears to zero at reset
// [RL4] First write byte is index, rest data
// [RL5] Local result: high byte 00h, nibble 15h
// [RL6] Remote result: high byte 01h, nibble 10h
// [RL7] Low nibble holds sixteenths of a degree
// [RL8] Results read-only, updated by converter unless frozen
// [RL9] High byte read first freezes matching low byte
// [RL10] Low byte read first freezes high byte
// [RL11] Reading another register ends the freeze
// [RL12] Master reads high byte then low byte
// [RL13] Results reset to zero
// [RL14] Each data byte written to 0Fh starts one conversion
// [RL15] Remote upper bound 12 bits: 07/0D, 13
// [RL16] Remote lower bound 12 bits: 08/0E, 14
// [RL17] Remote offset 12 bits at 11, 12
// [RL18] Remote critical bound at 19, reset 6Eh
// [RL19] Local critical bound at 20, reset 6Eh
// [RL20] Local upper bound read 05, write 0B
// [RL21] Local lower bound read 06, write 0C, reset zero
// [RL22] Writes to non-writable indices change nothing
`timescale 1ns/1ps
`default_nettype none
module tsr_regfile #(
  // Arbitrary identification value
  parameter logic [7:0] MAKER_ID = 8'hA7
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  // Serial engine, write side
  input  wire logic                 wr_txn_start,
  input  wire logic                 wr_byte_valid,
  input  wire logic [7:0]           wr_byte_data,
  input  wire logic                 txn_stop,
  // Serial engine, read side
  input  wire logic                 rd_byte_req,
  output logic                      rd_byte_valid,
  output logic [7:0]                rd_byte_data,
  // Converter results
  input  wire tsr_pkg::tsr_result_s local_result_bits,
  input  wire tsr_pkg::tsr_result_s remote_result_bits,
  // Condition flags
  input  wire logic [7:0]           status_flags,
  output logic                      status_read,
  // Converter control
  output logic                      one_shot_start,
  output tsr_pkg::tsr_ctrl_s        ctrl,
  // Observation
  output logic [7:0]                index_value
);

  function automatic logic hit(input logic [7:0] ix, input logic [7:0] off);
    hit = (ix == off);
  endfunction

  // Write transaction phase and index
  tsr_pkg::tsr_wphase_e phase_reg, phase_next;
  logic [7:0]           ptr_reg, ptr_next;
  logic                 data_we;

  always_comb begin
    phase_next = phase_reg;
    ptr_next   = ptr_reg;
    data_we    = 1'b0;
    if (wr_txn_start) begin
      phase_next = tsr_pkg::TSR_PTR; // RL2
    end else if (txn_stop) begin
      phase_next = tsr_pkg::TSR_IDLE;
    end else if (wr_byte_valid) begin
      unique case (phase_reg)
        tsr_pkg::TSR_IDLE: begin
          phase_next = tsr_pkg::TSR_IDLE;
        end
        tsr_pkg::TSR_PTR: begin
          ptr_next   = wr_byte_data; // RL4
          phase_next = tsr_pkg::TSR_DATA;
        end
        tsr_pkg::TSR_DATA: begin
          data_we    = 1'b1; // RL4
        end
        default: begin
          phase_next = tsr_pkg::TSR_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      phase_reg <= tsr_pkg::TSR_IDLE;
      ptr_reg   <= tsr_pkg::TSR_PTR_RST; // RL3
    end else begin
      phase_reg <= phase_next;
      ptr_reg   <= ptr_next; // RL1
    end
  end

  // Write strobes per index; an index with no write function gets none
  logic we_setup, we_interval, we_local_ub, we_local_lb;
  logic we_rub_msb, we_rlb_msb, we_one_shot;
  logic we_off_msb, we_off_lsb, we_rub_lsb, we_rlb_lsb;
  logic we_rcrit, we_lcrit, we_hyst, we_fault, we_ideal, we_smooth;

  always_comb begin
    we_setup    = data_we && hit(ptr_reg, tsr_pkg::TSR_WR_SETUP); // RL22
    we_interval = data_we && hit(ptr_reg, tsr_pkg::TSR_WR_INTERVAL);
    we_local_ub = data_we && hit(ptr_reg, tsr_pkg::TSR_WR_LOCAL_UB); // RL20
    we_local_lb = data_we && hit(ptr_reg, tsr_pkg::TSR_WR_LOCAL_LB); // RL21
    we_rub_msb  = data_we && hit(ptr_reg, tsr_pkg::TSR_WR_REMOTE_UB_MSB); // RL15
    we_rlb_msb  = data_we && hit(ptr_reg, tsr_pkg::TSR_WR_REMOTE_LB_MSB); // RL16
    we_one_shot = data_we && hit(ptr_reg, tsr_pkg::TSR_WR_ONE_SHOT); // RL14
    we_off_msb  = data_we && hit(ptr_reg, tsr_pkg::TSR_IX_OFFSET_MSB); // RL17
    we_off_lsb  = data_we && hit(ptr_reg, tsr_pkg::TSR_IX_OFFSET_LSB); // RL17
    we_rub_lsb  = data_we && hit(ptr_reg, tsr_pkg::TSR_IX_REMOTE_UB_LSB); // RL15
    we_rlb_lsb  = data_we && hit(ptr_reg, tsr_pkg::TSR_IX_REMOTE_LB_LSB); // RL16
    we_rcrit    = data_we && hit(ptr_reg, tsr_pkg::TSR_IX_REMOTE_CRIT); // RL18
    we_lcrit    = data_we && hit(ptr_reg, tsr_pkg::TSR_IX_LOCAL_CRIT); // RL19
    we_hyst     = data_we && hit(ptr_reg, tsr_pkg::TSR_IX_HYST);
    we_fault    = data_we && hit(ptr_reg, tsr_pkg::TSR_IX_FAULT_CNT);
    we_ideal    = data_we && hit(ptr_reg, tsr_pkg::TSR_IX_IDEALITY);
    we_smooth   = data_we && hit(ptr_reg, tsr_pkg::TSR_IX_SMOOTH);
  end

  // Byte-wide settings
  logic [7:0] setup_reg, setup_next;
  logic [3:0] interval_reg, interval_next;
  logic [7:0] local_ub_reg, local_ub_next;
  logic [7:0] local_lb_reg, local_lb_next;
  logic [7:0] rcrit_reg, rcrit_next;
  logic [7:0] lcrit_reg, lcrit_next;
  logic [7:0] hyst_reg, hyst_next;
  logic [3:0] fault_reg, fault_next;
  logic [7:0] ideal_reg, ideal_next;
  logic [1:0] smooth_reg, smooth_next;
  logic       one_shot_reg, one_shot_next;

  always_comb begin
    setup_next    = setup_reg;
    interval_next = interval_reg;
    local_ub_next = local_ub_reg;
    local_lb_next = local_lb_reg;
    rcrit_next    = rcrit_reg;
    lcrit_next    = lcrit_reg;
    hyst_next     = hyst_reg;
    fault_next    = fault_reg;
    ideal_next    = ideal_reg;
    smooth_next   = smooth_reg;
    one_shot_next = we_one_shot; // RL14
    if (we_setup) begin
      // Reserved bits are forced low since they must always be zero
      setup_next = 8'h00;
      setup_next[tsr_pkg::TSR_SETUP_MASK_BIT]  = wr_byte_data[tsr_pkg::TSR_SETUP_MASK_BIT];
      setup_next[tsr_pkg::TSR_SETUP_SD_BIT]    = wr_byte_data[tsr_pkg::TSR_SETUP_SD_BIT];
      setup_next[tsr_pkg::TSR_SETUP_PIN6_BIT]  = wr_byte_data[tsr_pkg::TSR_SETUP_PIN6_BIT];
      setup_next[tsr_pkg::TSR_SETUP_RANGE_BIT] = wr_byte_data[tsr_pkg::TSR_SETUP_RANGE_BIT];
    end
    if (we_interval) begin
      interval_next = wr_byte_data[3:0];
    end
    if (we_local_ub) begin
      local_ub_next = wr_byte_data; // RL20
    end
    if (we_local_lb) begin
      local_lb_next = wr_byte_data; // RL21
    end
    if (we_rcrit) begin
      rcrit_next = wr_byte_data; // RL18
    end
    if (we_lcrit) begin
      lcrit_next = wr_byte_data; // RL19
    end
    if (we_hyst) begin
      hyst_next = wr_byte_data;
    end
    if (we_fault) begin
      // Timeout enable in bit 7, count in bits 3 to 1; bit 0 is fixed high
      fault_next = {wr_byte_data[tsr_pkg::TSR_FAULT_TO_BIT], wr_byte_data[3:1]};
    end
    if (we_ideal) begin
      ideal_next = wr_byte_data;
    end
    if (we_smooth) begin
      smooth_next = wr_byte_data[1:0];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      setup_reg    <= tsr_pkg::TSR_SETUP_RST;
      interval_reg <= tsr_pkg::TSR_INTERVAL_RST;
      local_ub_reg <= tsr_pkg::TSR_LOCAL_UB_RST;
      local_lb_reg <= tsr_pkg::TSR_LOCAL_LB_RST; // RL21
      rcrit_reg    <= tsr_pkg::TSR_CRIT_RST; // RL18
      lcrit_reg    <= tsr_pkg::TSR_CRIT_RST; // RL19
      hyst_reg     <= tsr_pkg::TSR_HYST_RST;
      fault_reg    <= tsr_pkg::TSR_FAULT_RST;
      ideal_reg    <= tsr_pkg::TSR_IDEALITY_RST;
      smooth_reg   <= tsr_pkg::TSR_SMOOTH_RST;
      one_shot_reg <= 1'b0;
    end else begin
      setup_reg    <= setup_next;
      interval_reg <= interval_next;
      local_ub_reg <= local_ub_next;
      local_lb_reg <= local_lb_next;
      rcrit_reg    <= rcrit_next;
      lcrit_reg    <= lcrit_next;
      hyst_reg     <= hyst_next;
      fault_reg    <= fault_next;
      ideal_reg    <= ideal_next;
      smooth_reg   <= smooth_next;
      one_shot_reg <= one_shot_next;
    end
  end

  // Twelve-bit remote settings
  logic [11:0] rub_val, rlb_val, off_val;

  tsr_split12 #(
    .RST_VAL (tsr_pkg::TSR_REMOTE_UB_RST)
  ) u_remote_ub (
    .clk     (clk),
    .sys_rst (sys_rst),
    .wr_msb  (we_rub_msb),
    .wr_lsb  (we_rub_lsb),
    .wdata   (wr_byte_data),
    .value   (rub_val)
  );

  tsr_split12 #(
    .RST_VAL (tsr_pkg::TSR_REMOTE_LB_RST)
  ) u_remote_lb (
    .clk     (clk),
    .sys_rst (sys_rst),
    .wr_msb  (we_rlb_msb),
    .wr_lsb  (we_rlb_lsb),
    .wdata   (wr_byte_data),
    .value   (rlb_val)
  );

  tsr_split12 #(
    .RST_VAL (tsr_pkg::TSR_OFFSET_RST)
  ) u_remote_off (
    .clk     (clk),
    .sys_rst (sys_rst),
    .wr_msb  (we_off_msb),
    .wr_lsb  (we_off_lsb),
    .wdata   (wr_byte_data),
    .value   (off_val)
  );

  // Read events seen by the result pairs
  logic rd_l_hi, rd_l_lo, rd_r_hi, rd_r_lo;
  logic rd_l_other, rd_r_other;

  always_comb begin
    rd_l_hi    = rd_byte_req && hit(ptr_reg, tsr_pkg::TSR_RD_LOCAL_HI);
    rd_l_lo    = rd_byte_req && hit(ptr_reg, tsr_pkg::TSR_RD_LOCAL_LO);
    rd_r_hi    = rd_byte_req && hit(ptr_reg, tsr_pkg::TSR_RD_REMOTE_HI);
    rd_r_lo    = rd_byte_req && hit(ptr_reg, tsr_pkg::TSR_RD_REMOTE_LO);
    rd_l_other = rd_byte_req && !rd_l_hi && !rd_l_lo; // RL11
    rd_r_other = rd_byte_req && !rd_r_hi && !rd_r_lo; // RL11
  end

  logic [7:0] l_hi, l_lo, r_hi, r_lo;

  tsr_result_pair u_local (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .result   (local_result_bits),
    .rd_hi    (rd_l_hi),
    .rd_lo    (rd_l_lo),
    .rd_other (rd_l_other),
    .hi_byte  (l_hi),
    .lo_byte  (l_lo)
  );

  tsr_result_pair u_remote (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .result   (remote_result_bits),
    .rd_hi    (rd_r_hi),
    .rd_lo    (rd_r_lo),
    .rd_other (rd_r_other),
    .hi_byte  (r_hi),
    .lo_byte  (r_lo)
  );

  // Read data; unmapped and write-only indices answer zero
  logic [7:0] rd_mux;
  logic [7:0] rd_data_reg, rd_data_next;
  logic       rd_valid_reg, rd_valid_next;
  logic       stat_rd_reg, stat_rd_next;

  always_comb begin
    unique case (ptr_reg)
      tsr_pkg::TSR_RD_LOCAL_HI:      rd_mux = l_hi; // RL5
      tsr_pkg::TSR_RD_LOCAL_LO:      rd_mux = l_lo; // RL5
      tsr_pkg::TSR_RD_REMOTE_HI:     rd_mux = r_hi; // RL6
      tsr_pkg::TSR_RD_REMOTE_LO:     rd_mux = r_lo; // RL6
      tsr_pkg::TSR_RD_STATUS:        rd_mux = status_flags;
      tsr_pkg::TSR_RD_SETUP:         rd_mux = setup_reg;
      tsr_pkg::TSR_RD_INTERVAL:      rd_mux = {4'h0, interval_reg};
      tsr_pkg::TSR_RD_LOCAL_UB:      rd_mux = local_ub_reg; // RL20
      tsr_pkg::TSR_RD_LOCAL_LB:      rd_mux = local_lb_reg; // RL21
      tsr_pkg::TSR_RD_REMOTE_UB_MSB: rd_mux = rub_val[11:4]; // RL15
      tsr_pkg::TSR_RD_REMOTE_LB_MSB: rd_mux = rlb_val[11:4]; // RL16
      tsr_pkg::TSR_IX_OFFSET_MSB:    rd_mux = off_val[11:4]; // RL17
      tsr_pkg::TSR_IX_OFFSET_LSB:    rd_mux = {off_val[3:0], 4'h0}; // RL17
      tsr_pkg::TSR_IX_REMOTE_UB_LSB: rd_mux = {rub_val[3:0], 4'h0}; // RL15
      tsr_pkg::TSR_IX_REMOTE_LB_LSB: rd_mux = {rlb_val[3:0], 4'h0}; // RL16
      tsr_pkg::TSR_IX_REMOTE_CRIT:   rd_mux = rcrit_reg; // RL18
      tsr_pkg::TSR_IX_LOCAL_CRIT:    rd_mux = lcrit_reg; // RL19
      tsr_pkg::TSR_IX_HYST:          rd_mux = hyst_reg;
      tsr_pkg::TSR_IX_FAULT_CNT:     rd_mux = {fault_reg[3], 3'h0, fault_reg[2:0], 1'b1};
      tsr_pkg::TSR_IX_IDEALITY:      rd_mux = ideal_reg;
      tsr_pkg::TSR_IX_SMOOTH:        rd_mux = {6'h00, smooth_reg};
      tsr_pkg::TSR_RD_MAKER:         rd_mux = MAKER_ID;
      default:                       rd_mux = 8'h00;
    endcase
    rd_valid_next = rd_byte_req;
    stat_rd_next  = rd_byte_req && hit(ptr_reg, tsr_pkg::TSR_RD_STATUS);
    rd_data_next  = rd_byte_req ? rd_mux : rd_data_reg; // RL2
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data_reg  <= 8'h00;
      rd_valid_reg <= 1'b0;
      stat_rd_reg  <= 1'b0;
    end else begin
      rd_data_reg  <= rd_data_next;
      rd_valid_reg <= rd_valid_next;
      stat_rd_reg  <= stat_rd_next;
    end
  end

  // Outputs
  always_comb begin
    ctrl.mask_alert              = setup_reg[tsr_pkg::TSR_SETUP_MASK_BIT];
    ctrl.shutdown                = setup_reg[tsr_pkg::TSR_SETUP_SD_BIT];
    ctrl.pin6_critical_mode      = setup_reg[tsr_pkg::TSR_SETUP_PIN6_BIT];
    ctrl.wide_range              = setup_reg[tsr_pkg::TSR_SETUP_RANGE_BIT];
    ctrl.interval                = interval_reg;
    ctrl.local_upper_bound_bits  = local_ub_reg;
    ctrl.local_lower_bound_bits  = local_lb_reg;
    ctrl.remote_upper_bound_bits = rub_val;
    ctrl.remote_lower_bound_bits = rlb_val;
    ctrl.remote_offset_bits      = off_val;
    ctrl.remote_critical_bits    = rcrit_reg;
    ctrl.local_critical_bits     = lcrit_reg;
    ctrl.hysteresis_bits         = hyst_reg;
    ctrl.bus_timeout_en          = fault_reg[3];
    ctrl.fault_count             = fault_reg[2:0];
    ctrl.ideality_bits           = ideal_reg;
    ctrl.smoothing               = smooth_reg;
  end

  assign rd_byte_valid  = rd_valid_reg;
  assign rd_byte_data   = rd_data_reg;
  assign status_read    = stat_rd_reg;
  assign one_shot_start = one_shot_reg;
  assign index_value    = ptr_reg;

endmodule
`default_nettype wire

// *** testbench/tsr_regfile_assertions.sv ***
// Purpose: Port-level checks of the register file
// Assumes: One clock, asynchronous active-high reset
// Notes:   Bound to every register file instance
`timescale 1ns/1ps
`default_nettype none
module tsr_regfile_assertions (
  // Clock and reset
  input wire logic       clk,
  input wire logic       sys_rst,
  // Engine side
  input wire logic       wr_txn_start,
  input wire logic       wr_byte_valid,
  input wire logic [7:0] wr_byte_data,
  input wire logic       txn_stop,
  input wire logic       rd_byte_req,
  // Results
  input wire logic       rd_byte_valid,
  input wire logic [7:0] rd_byte_data,
  input wire logic       status_read,
  input wire logic       one_shot_start,
  input wire logic [7:0] index_value
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_read_answer: assert property (rd_byte_req |=> rd_byte_valid)
    else $error("read not answered");
  a_valid_cause: assert property (rd_byte_valid |-> $past(rd_byte_req))
    else $error("valid without request");
  a_data_hold: assert property (!rd_byte_req |=> $stable(rd_byte_data))
    else $error("read data moved");
  a_index_load: assert property (wr_txn_start ##1 (wr_byte_valid && !wr_txn_start
    && !txn_stop) |=> index_value == $past(wr_byte_data)) else $error("index not loaded");
  a_index_keep: assert property (!wr_byte_valid |=> $stable(index_value))
    else $error("index moved");
  a_nibble_zero: assert property (rd_byte_req && (index_value == 8'h10
    || index_value == 8'h15) |=> rd_byte_data[3:0] == 4'h0) else $error("low bits set");
  a_status_read: assert property (status_read |-> $past(rd_byte_req)
    && $past(index_value) == 8'h02) else $error("stray status pulse");
  a_one_shot: assert property (one_shot_start |-> $past(wr_byte_valid)
    && $past(index_value) == 8'h0F) else $error("stray one-shot");
  cover property (one_shot_start);
  cover property (status_read);
  cover property (rd_byte_req && index_value == 8'h15);
endmodule
bind tsr_regfile tsr_regfile_assertions chk_u (.clk, .sys_rst, .wr_txn_start, .wr_byte_valid,
  .wr_byte_data, .txn_stop, .rd_byte_req, .rd_byte_valid, .rd_byte_data, .status_read,
  .one_shot_start, .index_value);
`default_nettype wire

// *** testbench/tsr_master_model.sv ***
// Purpose: Serial engine stand-in feeding byte events
// Assumes: Strobes are one-cycle pulses set after a rising edge
// Notes:   Gap and stop cycles show an inverted byte so stale data cannot pass
`timescale 1ns/1ps
`default_nettype none
module tsr_master_model (
  // Clock
  input wire logic   clk,
  // Byte events
  output logic       wr_txn_start,
  output logic       wr_byte_valid,
  output logic [7:0] wr_byte_data,
  output logic       txn_stop,
  output logic       rd_byte_req
);
  initial begin
    {wr_txn_start, wr_byte_valid, txn_stop, rd_byte_req} = 4'h0;
    wr_byte_data = 8'h00;
  end
  task automatic ev(input logic [3:0] s, input logic [7:0] d);
    @(posedge clk);
    {wr_txn_start, wr_byte_valid, txn_stop, rd_byte_req} <= s;
    wr_byte_data <= d;
  endtask
  // Gap cycles model a slow master before each data byte
  task automatic wr(input logic [7:0] ix, input logic [7:0] d, input int n, input int gap);
    ev(4'h8, ~ix);
    ev(4'h4, ix);
    for (int i = 0; i < n; i++) begin
      repeat (gap) ev(4'h0, ~ix);
      ev(4'h4, d);
    end
    ev(4'h2, ~d);
    ev(4'h0, d);
  endtask
  task automatic rd();
    ev(4'h1, 8'hA5);
    ev(4'h0, 8'h5A);
  endtask
endmodule
`default_nettype wire

// *** testbench/tb_tsr_regfile.sv ***
// Purpose: Self-checking bench of the register file
// Assumes: Master model makes byte events; bench drives results
// Notes:   Read bytes are checked in order through a queue
`timescale 1ns/1ps
`default_nettype none
module tb_tsr_regfile;
  logic                 clk;
  logic                 sys_rst;
  logic                 wr_txn_start, wr_byte_valid, txn_stop, rd_byte_req;
  logic                 rd_byte_valid, status_read, one_shot_start;
  logic [7:0]           wr_byte_data, rd_byte_data, status_flags, index_value, d, e;
  logic [11:0]          nv;
  tsr_pkg::tsr_result_s local_result_bits, remote_result_bits;
  tsr_pkg::tsr_ctrl_s   ctrl;
  logic [7:0]           q[$];
  logic [0:15][7:0]     rr = 128'h03040506070811121314192021222324;
  logic [0:15][7:0]     rs = 128'h000855005500000000006E6E0A010000;
  logic [0:15][7:0]     wi = 128'h090A0B0C0D0E11121314192021222324;
  logic [0:15][7:0]     wm = 128'hE40FFFFFFFFFFFF0F0F0FFFFFF8EFF03;
  logic [0:7][7:0]      ro = 64'h0305071015FE0200;
  int                   n_errors, n_tests, n_os, cyc, seed;
  // Arbitrary identification value
  tsr_regfile #(.MAKER_ID(8'h3C)) dut_u (.clk, .sys_rst, .wr_txn_start, .wr_byte_valid,
    .wr_byte_data, .txn_stop, .rd_byte_req, .rd_byte_valid, .rd_byte_data, .local_result_bits,
    .remote_result_bits, .status_flags, .status_read, .one_shot_start, .ctrl, .index_value);
  tsr_master_model m_u (.clk, .wr_txn_start, .wr_byte_valid, .wr_byte_data, .txn_stop,
    .rd_byte_req);
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic rd(input logic [7:0] x);
    q.push_back(x);
    m_u.rd();
  endtask
  task automatic up(input bit r, input logic [11:0] v);
    @(posedge clk);
    if (r) remote_result_bits <= {1'b1, v};
    else local_result_bits <= {1'b1, v};
    @(posedge clk);
    local_result_bits.upd <= 1'b0;
    remote_result_bits.upd <= 1'b0;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (one_shot_start === 1'b1) n_os++;
    if (rd_byte_valid === 1'b1) begin
      e = q.pop_front();
      chk(rd_byte_data, e);
    end
    if (cyc == 20000) begin
      n_errors++;
      close_out();
    end
  end
  initial begin
    seed = 32'had2a;
    sys_rst = 1'b1;
    local_result_bits = '0;
    remote_result_bits = '0;
    status_flags = 8'h00;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    status_flags <= 8'($random(seed));
    rd(8'h00);
    for (int i = 0; i < 16; i++) begin
      m_u.wr(rr[i], 8'h00, 0, 0);
      rd(rs[i]);
    end
    for (int i = 0; i < 16; i++) begin
      d = 8'($random(seed));
      m_u.wr(wi[i], d, 1, i % 3);
      m_u.wr(rr[i], 8'h00, 0, 0);
      rd(d & wm[i] | {7'h00, wi[i] == 8'h22});
    end
    m_u.wr(8'h0B, 8'h3A, 2, 1);
    for (int i = 0; i < 8; i++) m_u.wr(ro[i], 8'($random(seed)), 1, 0);
    rd(8'h00);
    m_u.wr(8'hFE, 8'h00, 0, 0);
    rd(8'h3C);
    m_u.wr(8'h05, 8'h00, 0, 0);
    rd(8'h3A);
    chk(ctrl.local_upper_bound_bits, 8'h3A);
    m_u.wr(8'h0F, 8'h00, 0, 0);
    m_u.wr(8'h0F, 8'h77, 2, 1);
    @(negedge clk) chk(8'(n_os), 8'h02);
    nv = 12'($random(seed));
    up(1'b0, nv);
    m_u.wr(8'h00, 8'h00, 0, 0);
    rd(nv[11:4]);
    // Update lands between the two reads of one pair
    up(1'b0, ~nv);
    m_u.wr(8'h15, 8'h00, 0, 0);
    rd({nv[3:0], 4'h0});
    nv = 12'($random(seed));
    up(1'b1, nv);
    m_u.wr(8'h10, 8'h00, 0, 0);
    rd({nv[3:0], 4'h0});
    up(1'b1, ~nv);
    m_u.wr(8'h01, 8'h00, 0, 0);
    rd(nv[11:4]);
    rd(nv[11:4]);
    m_u.wr(8'h02, 8'h00, 0, 0);
    rd(status_flags);
    up(1'b1, nv);
    m_u.wr(8'h10, 8'h00, 0, 0);
    rd({nv[3:0], 4'h0});
    repeat (4) @(posedge clk);
    chk(8'(q.size()), 8'h00);
    close_out();
  end
endmodule
`default_nettype wire
